// File: hw/two_wire_eeprom_slave.sv
`default_nettype none
module two_wire_eeprom_slave
	import ee_slave_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary value
	parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
	// clocks and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sample_clk,
	// two-wire pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// straps and protection
	input wire logic device_select_bit_0,
	input wire logic device_select_bit_1,
	input wire logic device_select_bit_2,
	input wire logic wp_in,
	// status
	output logic standby,
	output logic write_busy
);

	// ---- link domain: sample, filter ----
	logic [1:0] brst_ff, nxt_brst;
	logic [1:0] pin_meta_ff, pin_sync_ff, hist_a_ff, hist_b_ff, filt_ff;
	logic [1:0] nxt_hist_a, nxt_hist_b, nxt_filt;

	// bring the core reset over before it is used here
	always_comb
	begin
		nxt_brst = {brst_ff[0], rst_n};
		nxt_hist_a = pin_sync_ff;
		nxt_hist_b = hist_a_ff;
		// majority of three rejects single-sample spikes
		nxt_filt = (pin_sync_ff & hist_a_ff) | (pin_sync_ff & hist_b_ff)
			| (hist_a_ff & hist_b_ff);
	end

	always_ff @(posedge sample_clk)
	begin
		brst_ff <= nxt_brst;
		pin_meta_ff <= {scl_in, sda_in};
		pin_sync_ff <= pin_meta_ff;
		if (!brst_ff[1])
		begin
			hist_a_ff <= 2'h3;
			hist_b_ff <= 2'h3;
			filt_ff <= 2'h3;
		end
		else
		begin
			hist_a_ff <= nxt_hist_a;
			hist_b_ff <= nxt_hist_b;
			filt_ff <= nxt_filt;
		end
	end

	// ---- core domain: levels crossed by two flops ----
	logic [1:0] lk_meta_ff, lk_sync_ff, lk_prev_ff;
	logic [3:0] strap_meta_ff, strap_sync_ff;
	logic scl_s, sda_s, scl_p, sda_p, wp_s;
	logic [2:0] sel_s;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			lk_meta_ff <= 2'h3;
			lk_sync_ff <= 2'h3;
			lk_prev_ff <= 2'h3;
			strap_meta_ff <= 4'hf;
			strap_sync_ff <= 4'hf;
		end
		else
		begin
			lk_meta_ff <= filt_ff;
			lk_sync_ff <= lk_meta_ff;
			lk_prev_ff <= lk_sync_ff;
			strap_meta_ff <= {wp_in, device_select_bit_2,
				device_select_bit_1, device_select_bit_0};
			strap_sync_ff <= strap_meta_ff;
		end
	end

	assign scl_s = lk_sync_ff[1];
	assign sda_s = lk_sync_ff[0];
	assign scl_p = lk_prev_ff[1];
	assign sda_p = lk_prev_ff[0];
	assign wp_s = strap_sync_ff[3];
	assign sel_s = strap_sync_ff[2:0];

	// bus events, all judged on filtered levels
	logic start_ev, stop_ev, scl_rise, scl_fall;
	assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;

	// ---- protocol engine ----
	link_state_e state_ff, nxt_state;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [1:0] byte_sel_ff, nxt_byte_sel;
	logic rd_mode_ff, nxt_rd_mode;
	logic [7:0] addr_ff, nxt_addr;
	logic [PAGE_W-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [PAGE_BYTES-1:0] mask_ff, nxt_mask;
	logic [DATA_W-1:0] pg_data_ff [PAGE_BYTES];
	logic oe_n_ff, nxt_oe_n;
	logic mack_ff, nxt_mack;
	logic standby_ff, nxt_standby;
	logic busy_ff, nxt_busy;
	logic commit_go, pg_we, load_tx, dev_match;
	logic [DATA_W-1:0] mem_rdata;

	assign dev_match = (shift_ff[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
		&& (shift_ff[SEL_MSB:SEL_LSB] == sel_s);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_byte_sel = byte_sel_ff;
		nxt_rd_mode = rd_mode_ff;
		nxt_addr = addr_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_mask = mask_ff;
		nxt_oe_n = oe_n_ff;
		nxt_mack = mack_ff;
		nxt_standby = standby_ff;
		commit_go = 1'b0;
		pg_we = 1'b0;
		load_tx = 1'b0;
		if (busy_ff)
		begin
			// bus is deaf while the array is being written
			nxt_state = st_idle;
			nxt_oe_n = 1'b1;
		end
		else if (start_ev)
		begin
			// also a repeated start: abort and relisten
			nxt_state = st_rx;
			nxt_bit_cnt = '0;
			nxt_byte_sel = BYTE_DEV;
			nxt_mask = '0;
			nxt_oe_n = 1'b1;
			nxt_standby = 1'b0;
		end
		else if (stop_ev)
		begin
			nxt_state = st_idle;
			nxt_oe_n = 1'b1;
			nxt_standby = 1'b1;
			if (state_ff != st_idle && !rd_mode_ff && mask_ff != '0
				&& !wp_s)
				commit_go = 1'b1;
		end
		else
		begin
			unique case (state_ff)
				st_idle, st_ignore:
				begin
				end
				st_rx:
				begin
					if (scl_rise)
					begin
						// sampled on rise, where SDA is stable
						nxt_shift = {shift_ff[6:0], sda_s};
						nxt_bit_cnt = bit_cnt_ff + 4'h1;
					end
					else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE)
					begin
						nxt_bit_cnt = '0;
						nxt_state = st_ack;
						nxt_oe_n = 1'b0;
						unique case (byte_sel_ff)
							BYTE_DEV:
							begin
								nxt_rd_mode = shift_ff[DIR_BIT];
								nxt_byte_sel = BYTE_MEM;
								if (!dev_match)
								begin
									nxt_state = st_ignore;
									nxt_oe_n = 1'b1;
									nxt_standby = 1'b1;
								end
							end
							BYTE_MEM:
							begin
								nxt_addr = shift_ff;
								nxt_wr_ptr = shift_ff[PAGE_W-1:0];
								nxt_byte_sel = BYTE_DATA;
							end
							default:
							begin
								// later bytes overwrite within the page
								pg_we = 1'b1;
								nxt_mask[wr_ptr_ff] = 1'b1;
								nxt_wr_ptr = wr_ptr_ff + 3'h1;
								nxt_addr = {addr_ff[7:PAGE_W],
									wr_ptr_ff + 3'h1};
							end
						endcase
					end
				end
				st_ack:
				begin
					if (scl_fall)
					begin
						nxt_oe_n = 1'b1;
						if (rd_mode_ff)
							load_tx = 1'b1;
						else
							nxt_state = st_rx;
					end
				end
				st_tx:
				begin
					if (scl_fall)
					begin
						nxt_bit_cnt = bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == LAST_TX_BIT)
						begin
							nxt_oe_n = 1'b1;
							nxt_state = st_mack;
						end
						else
						begin
							nxt_shift = {shift_ff[6:0], 1'b0};
							nxt_oe_n = shift_ff[6];
						end
					end
				end
				st_mack:
				begin
					if (scl_rise)
						nxt_mack = ~sda_s;
					else if (scl_fall)
					begin
						if (mack_ff)
							load_tx = 1'b1;
						else
							nxt_state = st_ignore;
					end
				end
			endcase
		end
		if (load_tx)
		begin
			// wraps FFh to 00h by width
			nxt_shift = mem_rdata;
			nxt_oe_n = mem_rdata[7];
			nxt_addr = addr_ff + ADDR_STEP;
			nxt_bit_cnt = '0;
			nxt_state = st_tx;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_ff <= st_idle;
			bit_cnt_ff <= '0;
			shift_ff <= '0;
			byte_sel_ff <= BYTE_DEV;
			rd_mode_ff <= 1'b0;
			addr_ff <= '0;
			wr_ptr_ff <= '0;
			mask_ff <= '0;
			oe_n_ff <= 1'b1;
			mack_ff <= 1'b0;
			standby_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			byte_sel_ff <= nxt_byte_sel;
			rd_mode_ff <= nxt_rd_mode;
			addr_ff <= nxt_addr;
			wr_ptr_ff <= nxt_wr_ptr;
			mask_ff <= nxt_mask;
			oe_n_ff <= nxt_oe_n;
			mack_ff <= nxt_mack;
			standby_ff <= nxt_standby;
		end
		if (pg_we)
			pg_data_ff[wr_ptr_ff] <= shift_ff;
	end

	// ---- commit of the page, then the timed write window ----
	logic commit_ff, nxt_commit;
	logic [PAGE_W-1:0] cidx_ff, nxt_cidx;
	logic [31:0] timer_ff, nxt_timer;
	logic mem_we;

	always_comb
	begin
		nxt_commit = commit_ff;
		nxt_cidx = cidx_ff;
		nxt_timer = timer_ff;
		if (commit_go)
		begin
			nxt_commit = 1'b1;
			nxt_cidx = '0;
		end
		else if (commit_ff)
		begin
			nxt_cidx = cidx_ff + 3'h1;
			if (cidx_ff == LAST_PAGE_SLOT)
			begin
				nxt_commit = 1'b0;
				nxt_timer = 32'(WRITE_CYCLES_P);
			end
		end
		else if (timer_ff != '0)
			nxt_timer = timer_ff - 32'h1;
		nxt_busy = nxt_commit | (nxt_timer != '0);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			commit_ff <= 1'b0;
			cidx_ff <= '0;
			timer_ff <= '0;
			busy_ff <= 1'b0;
		end
		else
		begin
			commit_ff <= nxt_commit;
			cidx_ff <= nxt_cidx;
			timer_ff <= nxt_timer;
			busy_ff <= nxt_busy;
		end
	end

	// only touched slots are written; protect pin checked again
	assign mem_we = commit_ff & mask_ff[cidx_ff] & ~wp_s;

	ee_mem_array #(
		.DEPTH(MEM_DEPTH),
		.AW(ADDR_W),
		.DW(DATA_W)
	) u_mem (
		.clk(core_clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr({addr_ff[7:PAGE_W], cidx_ff}),
		.wdata(pg_data_ff[cidx_ff]),
		.raddr(addr_ff),
		.rdata(mem_rdata)
	);

	// open drain: the data level is always low, only enable moves
	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_ff;
	assign standby = standby_ff;
	assign write_busy = busy_ff;

	// ---- checks ----
	sequence s_commit_done;
		$fell(commit_ff);
	endsequence
	sequence s_still_busy;
		busy_ff [*8];
	endsequence

	property p_addr_ack;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == st_rx && scl_fall && bit_cnt_ff == BITS_PER_BYTE
		&& byte_sel_ff == BYTE_DEV && dev_match && !busy_ff
		&& !start_ev && !stop_ev) |=> !sda_oe_n;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address word not acknowledged");

	property p_silent_busy;
		@(posedge core_clk) disable iff (!rst_n)
		busy_ff |=> sda_oe_n;
	endproperty
	a_silent_busy: assert property (p_silent_busy)
		else $error("SDA driven during internal write");

	property p_start;
		@(posedge core_clk) disable iff (!rst_n)
		(start_ev && !busy_ff) |=> (state_ff == st_rx && bit_cnt_ff == 4'h0
		&& !standby);
	endproperty
	a_start: assert property (p_start)
		else $error("START did not restart reception");

	property p_stop;
		@(posedge core_clk) disable iff (!rst_n)
		(stop_ev && !busy_ff) |=> (state_ff == st_idle && standby
		&& sda_oe_n);
	endproperty
	a_stop: assert property (p_stop)
		else $error("STOP did not return to standby");

	property p_drive_scl_low;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(sda_oe_n) |-> !$past(scl_s);
	endproperty
	a_drive_scl_low: assert property (p_drive_scl_low)
		else $error("SDA pulled low while SCL high");

	property p_ack_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == st_ack && !sda_oe_n && !scl_fall && !start_ev
		&& !stop_ev && !busy_ff) |=> !sda_oe_n;
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("acknowledge released early");

	property p_nack_release;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == st_mack && scl_fall && !mack_ff && !start_ev
		&& !stop_ev && !busy_ff) |=> (sda_oe_n && state_ff == st_ignore);
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("SDA not released after master nack");

	property p_addr_step;
		@(posedge core_clk) disable iff (!rst_n)
		load_tx |=> addr_ff == $past(addr_ff) + ADDR_STEP;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("address register did not step");

	property p_wp_block;
		@(posedge core_clk) disable iff (!rst_n)
		mem_we |-> !wp_s;
	endproperty
	a_wp_block: assert property (p_wp_block)
		else $error("array written with protect pin high");

	property p_busy_after_commit;
		@(posedge core_clk) disable iff (!rst_n)
		s_commit_done |-> s_still_busy;
	endproperty
	a_busy_after_commit: assert property (p_busy_after_commit)
		else $error("busy window ended too soon");

endmodule : two_wire_eeprom_slave
`default_nettype wire

// File: hw/ee_slave_pkg.sv
`default_nettype none
package ee_slave_pkg;

	// core clock and self-timed write window
	localparam int CLK_PERIOD_NS = 50;
	localparam int WRITE_TIME_US = 5000;
	// a least time, so the cycle count rounds up
	localparam int WRITE_CYCLES =
		(WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// memory array shape
	localparam int MEM_DEPTH = 256;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PAGE_BYTES = 8;
	localparam int PAGE_W = 3;

	// bit counting within one byte, slot counting within one page
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [2:0] LAST_PAGE_SLOT = 3'h7;

	// which byte of a transfer is being received
	localparam logic [1:0] BYTE_DEV = 2'h0;
	localparam logic [1:0] BYTE_MEM = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;

	// address word layout: type code, select bits, direction
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 1;
	localparam int DIR_BIT = 0;

	localparam logic [7:0] ADDR_STEP = 8'h01;

	typedef enum logic [2:0] {
		st_idle,
		st_rx,
		st_ack,
		st_tx,
		st_mack,
		st_ignore
	} link_state_e;

endpackage : ee_slave_pkg
`default_nettype wire

// File: hw/ee_mem_array.sv
`default_nettype none
module ee_mem_array #(
	parameter int DEPTH = 256,
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port, data one cycle after the address
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rdata_ff;

	// array has no reset: contents survive a link reset
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// registered read port
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_ff <= '0;
		else
			rdata_ff <= mem[raddr];
	end

	assign rdata = rdata_ff;

endmodule : ee_mem_array
`default_nettype wire

// File: tb/two_wire_master_model.sv
`default_nettype none
module two_wire_master_model (
	// timing reference
	input wire logic clk,
	// bus pins, data released high by the pull-up
	output logic scl,
	output logic sda_rel,
	input wire logic sda_wire
);
	timeunit 1ns;
	timeprecision 100ps;
	int hc = 25; // half bit in core cycles: 25 fast, 100 standard
	// pins move just after a core edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// bus idle with both lines high
	initial
	begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// also serves as repeated start while clock is low
	task automatic start();
		sda_rel = 1'b1;
		tick(hc / 2);
		scl = 1'b1;
		tick(hc);
		sda_rel = 1'b0;
		tick(hc);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tick(hc / 2);
		sda_rel = 1'b0;
		tick(hc / 2);
		scl = 1'b1;
		tick(hc);
		sda_rel = 1'b1;
		tick(hc);
	endtask : stop
	// data moves only in the low half, sampled mid high
	task automatic bit_io(input logic b, output logic got);
		tick(hc / 2);
		sda_rel = b;
		tick(hc / 2);
		scl = 1'b1;
		tick(hc / 2);
		got = sda_wire;
		tick(hc / 2);
		scl = 1'b0;
	endtask : bit_io
	// eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
		input logic ack_bit, output logic ack_seen);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_bit, ack_seen);
	endtask : byte_io
	// clock out any half finished transfer with data released
	task automatic recover();
		logic g;
		repeat (9) bit_io(1'b1, g);
	endtask : recover
endmodule : two_wire_master_model
`default_nettype wire

// File: tb/two_wire_eeprom_slave_tb.sv
`default_nettype none
module two_wire_eeprom_slave_tb;
	import ee_slave_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary value
	logic core_clk, sample_clk, rst_n, wp_in;
	logic scl, sda_rel, sda_wire, sda_out, sda_oe_n, standby, write_busy;
	logic [2:0] sel;
	logic [7:0] rx;
	logic ack;
	int mismatches = 0;
	int checked = 0;
	int mem [256];
	int ptr;
	// open drain data line with pull-up
	assign sda_wire = sda_rel & (sda_oe_n | sda_out);
	// short write time keeps the run brief
	two_wire_eeprom_slave #(.DEV_TYPE(DEV_TYPE), .WRITE_CYCLES_P(2000)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .sample_clk(sample_clk),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .device_select_bit_0(sel[0]),
		.device_select_bit_1(sel[1]), .device_select_bit_2(sel[2]),
		.wp_in(wp_in), .standby(standby), .write_busy(write_busy));
	two_wire_master_model m (.clk(core_clk), .scl(scl), .sda_rel(sda_rel),
		.sda_wire(sda_wire));
	// core clock 50 ns, link sampling clock 12 ns at an odd phase
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		sample_clk = 1'b0;
		#3.7;
		forever #6 sample_clk = ~sample_clk;
	end
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic dev_word(input logic [3:0] ty, input logic [2:0] s,
		input logic rw, input logic nack);
		m.byte_io({ty, s, rw}, rx, 1'b1, ack);
		chk("address ack", {7'h0, nack}, {7'h0, ack});
	endtask : dev_word
	// page slots wrap; nothing lands while protected
	task automatic write_seq(input logic [7:0] a, input int n);
		logic [7:0] d;
		m.start();
		dev_word(DEV_TYPE, sel, 1'b0, 1'b0);
		m.byte_io(a, rx, 1'b1, ack);
		chk("mem addr ack", 8'h00, {7'h0, ack});
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			m.byte_io(d, rx, 1'b1, ack);
			chk("data ack", 8'h00, {7'h0, ack});
			if (!wp_in)
				mem[{a[7:3], 3'h0} + (int'(a) + i) % 8] = d;
		end
		ptr = {a[7:3], 3'h0} + (int'(a) + n) % 8;
		m.stop();
	endtask : write_seq
	// busy must refuse a poll, then end within a bounded wait
	task automatic poll_busy();
		m.tick(10);
		chk("busy", 8'h01, {7'h0, write_busy});
		m.start();
		dev_word(DEV_TYPE, sel, 1'b0, 1'b1);
		m.stop();
		for (int i = 0; i < 4000 && write_busy === 1'b1; i++)
			m.tick(1);
		chk("busy end", 8'h00, {7'h0, write_busy});
	endtask : poll_busy
	// dummy write that only loads the address
	task automatic set_addr(input logic [7:0] a);
		m.start();
		dev_word(DEV_TYPE, sel, 1'b0, 1'b0);
		m.byte_io(a, rx, 1'b1, ack);
		chk("mem addr ack", 8'h00, {7'h0, ack});
		ptr = a;
	endtask : set_addr
	task automatic read_seq(input int n);
		m.start();
		dev_word(DEV_TYPE, sel, 1'b1, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			m.byte_io(8'hff, rx, i == n - 1, ack);
			chk("read data", 8'(mem[ptr]), rx);
			ptr = (ptr + 1) % 256;
		end
		m.tick(4);
		chk("released", 8'h01, {7'h0, sda_oe_n});
		m.stop();
		m.tick(10);
		chk("standby", 8'h01, {7'h0, standby});
	endtask : read_seq
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// hang guard, well beyond the expected run
	initial
	begin
		repeat (95000) @(posedge core_clk);
		mismatches++;
		end_of_test();
	end
	initial
	begin
		ptr = $urandom(32'h245d10ee);
		sel = 3'($urandom);
		wp_in = 1'b0;
		rst_n = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		m.tick(20);
		chk("standby", 8'h01, {7'h0, standby});
		chk("sda enable", 8'h01, {7'h0, sda_oe_n});
		$display("test reset done");
		m.recover();
		m.start();
		dev_word(~DEV_TYPE, sel, 1'b0, 1'b1);
		m.start();
		dev_word(DEV_TYPE, sel ^ 3'h4, 1'b1, 1'b1);
		m.start();
		dev_word(DEV_TYPE, sel ^ 3'h1, 1'b0, 1'b1);
		m.start();
		dev_word(DEV_TYPE, sel ^ 3'h2, 1'b1, 1'b1);
		m.stop();
		$display("test select done");
		// new straps, so every select pin takes part in matching
		sel = 3'($urandom);
		m.tick(4);
		write_seq(8'h03, 10);
		poll_busy();
		set_addr(8'h00);
		read_seq(8);
		$display("test page done");
		// standard rate for this write
		m.hc = 100;
		write_seq(8'hfe, 2);
		m.hc = 25;
		poll_busy();
		set_addr(8'hfe);
		read_seq(4);
		read_seq(1);
		$display("test wrap done");
		sel = 3'($urandom);
		wp_in = 1'b1;
		m.tick(4);
		write_seq(8'h05, 1);
		m.tick(10);
		chk("wp busy", 8'h00, {7'h0, write_busy});
		wp_in = 1'b0;
		set_addr(8'h05);
		read_seq(1);
		$display("test protect done");
		// second reset: address register back to zero, array kept
		rst_n = 1'b0;
		m.tick(3);
		rst_n = 1'b1;
		m.tick(20);
		ptr = 0;
		read_seq(1);
		$display("test second reset done");
		end_of_test();
	end
endmodule : two_wire_eeprom_slave_tb
`default_nettype wire
